/* File: pkg/ddrc_consts.svh */
// timing and field constants for the ddr2 command controller
`ifndef DDRC_CONSTS_SVH
`define DDRC_CONSTS_SVH
`define DDRC_CLK_MHZ       50
`define DDRC_T_RC_NS       55
`define DDRC_T_RRD_NS      10
`define DDRC_T_RCD_NS      15
`define DDRC_T_RP_NS       15
`define DDRC_T_RFC_NS      75
`define DDRC_T_XSNR_NS     200
`define DDRC_T_AOFD_NS     10
`define DDRC_T_MOD_MAX_NS  12
`define DDRC_T_WR_NS       15
`define DDRC_T_REFI_NS     7800
`define DDRC_CYC_MIN(ns)   ((((ns) * `DDRC_CLK_MHZ) + 999) / 1000 < 1 ? 1 : ((((ns) * `DDRC_CLK_MHZ) + 999) / 1000))
`define DDRC_CYC_MAX(ns)   ((((ns) * `DDRC_CLK_MHZ) / 1000) < 1 ? 1 : (((ns) * `DDRC_CLK_MHZ) / 1000))
`define DDRC_TCCD          2
`define DDRC_AL_MAX        4
`define DDRC_AP_BIT        10
`define DDRC_COL_W         9
`define DDRC_ROW_W         12
`define DDRC_ADDR_W        13
`define DDRC_BANKS         4
`define DDRC_POSTED_MAX    8
`define DDRC_CNT_W         16
`define DDRC_EMR1_BA       2'h1
`define DDRC_REFI_DEF      390
`define DDRC_AP_MARGIN     8
`endif

/* File: pkg/ddrc_pkg.sv */
// types for the ddr2 command controller
package ddrc_pkg;
	typedef enum logic [3:0] {
		DDRC_OP_NONE,
		DDRC_OP_ACT,
		DDRC_OP_RD,
		DDRC_OP_WR,
		DDRC_OP_PREA,
		DDRC_OP_REF,
		DDRC_OP_EMRS1,
		DDRC_OP_SRE,
		DDRC_OP_SRX
	} ddrc_op_e;
	typedef struct packed {
		logic       cs_n;
		logic       ras_n;
		logic       cas_n;
		logic       we_n;
		logic [1:0] ba;
		logic [12:0] addr;
	} ddrc_cmd_s;
	typedef struct packed {
		ddrc_op_e   op;
		logic [1:0] bank;
		logic [11:0] row;
		logic [8:0] col;
		logic       auto_precharge_flag;
		logic [12:0] mode_bits;
	} ddrc_req_s;
endpackage : ddrc_pkg

/* File: design/ddrc_timer.sv */
// down counter used for each spacing guard
`timescale 1ns/1ps
module ddrc_timer
	import ddrc_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              done
);
	logic [W-1:0] cnt_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= value;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
	assign done = (cnt_q == '0);
endmodule : ddrc_timer

/* File: design/ddrc_host.sv */
// ddr2 command controller driving the device command pins
`timescale 1ns/1ps
`include "ddrc_consts.svh"
module ddrc_host
	import ddrc_pkg::*;
#(
	parameter int REFI_CYC = (`DDRC_T_REFI_NS * `DDRC_CLK_MHZ) / 1000
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire ddrc_req_s   req,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [2:0]  add_lat,
	input  wire logic        clk_stable,
	input  wire logic        odt_want,
	output ddrc_cmd_s        cmd,
	output logic             cke,
	output logic             odt,
	output logic [1:0]       open_banks_lo,
	output logic [1:0]       open_banks_hi,
	output logic             in_self_refresh,
	output logic             refresh_due,
	output logic             req_error
);
	localparam int T_RC    = `DDRC_CYC_MIN(`DDRC_T_RC_NS);
	localparam int T_RRD   = `DDRC_CYC_MIN(`DDRC_T_RRD_NS);
	localparam int T_RFC   = `DDRC_CYC_MIN(`DDRC_T_RFC_NS);
	localparam int T_XSNR  = `DDRC_CYC_MIN(`DDRC_T_XSNR_NS);
	localparam int T_AOFD  = `DDRC_CYC_MIN(`DDRC_T_AOFD_NS);
	localparam int T_MODX  = `DDRC_CYC_MIN(`DDRC_T_MOD_MAX_NS);
	localparam int T_RCD   = `DDRC_CYC_MIN(`DDRC_T_RCD_NS);
	localparam int T_RPAP  = `DDRC_CYC_MIN(`DDRC_T_RP_NS + `DDRC_T_WR_NS) + `DDRC_AP_MARGIN;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_ODT_OFF,
		ST_MOD_WAIT,
		ST_SELF,
		ST_EXIT
	} ddrc_st_e;

	logic [1:0] rst_sync_q;
	logic       rst_n;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// clock stable comes from the clock generator, off this domain
	logic [1:0] stab_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stab_q <= 2'h0;
		end else begin
			stab_q <= {stab_q[0], clk_stable};
		end
	end

	ddrc_st_e st_q;
	logic [`DDRC_BANKS-1:0] open_q;
	logic [`DDRC_BANKS-1:0] rc_done;
	logic [`DDRC_BANKS-1:0] rc_load;
	logic rrd_done, rfc_done, ccd_done, wait_done;
	logic wait_load;
	logic [`DDRC_CNT_W-1:0] wait_val;
	logic need_ref_q;
	logic [3:0] posted_q;
	logic [`DDRC_CNT_W-1:0] refi_q;
	logic issue;
	logic [1:0] bank;

	function automatic ddrc_cmd_s mk(input logic r, input logic c, input logic w,
		input logic [1:0] b, input logic [12:0] a);
		mk = '{cs_n: 1'b0, ras_n: r, cas_n: c, we_n: w, ba: b, addr: a};
	endfunction : mk

	assign bank = req.bank;

	genvar gi;
	generate
		for (gi = 0; gi < `DDRC_BANKS; gi++) begin : g_rc
			ddrc_timer #(.W(`DDRC_CNT_W)) u_rc (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.load     (rc_load[gi]),
				.value    (`DDRC_CNT_W'(T_RC)),
				.done     (rc_done[gi])
			);
			assign rc_load[gi] = issue && req.op == DDRC_OP_ACT && bank == 2'(gi);
		end
	endgenerate

	ddrc_timer #(.W(`DDRC_CNT_W)) u_rrd (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (issue && req.op == DDRC_OP_ACT),
		.value    (`DDRC_CNT_W'(T_RRD)),
		.done     (rrd_done)
	);
	ddrc_timer #(.W(`DDRC_CNT_W)) u_rfc (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (issue && req.op == DDRC_OP_REF),
		.value    (`DDRC_CNT_W'(T_RFC)),
		.done     (rfc_done)
	);
	ddrc_timer #(.W(`DDRC_CNT_W)) u_ccd (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (issue && (req.op == DDRC_OP_RD || req.op == DDRC_OP_WR)),
		.value    (`DDRC_CNT_W'(`DDRC_TCCD - 1)),
		.done     (ccd_done)
	);
	ddrc_timer #(.W(`DDRC_CNT_W)) u_wait (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (wait_load),
		.value    (wait_val),
		.done     (wait_done)
	);

	// legality of the request against bank and spacing state
	logic ok, bad;
	always_comb begin
		ok  = 1'b0;
		bad = 1'b0;
		unique case (req.op)
			DDRC_OP_NONE:  ok = 1'b0;
			DDRC_OP_ACT: begin
				bad = open_q[bank];
				ok  = !bad && rc_done[bank] && rrd_done && rfc_done;
			end
			DDRC_OP_RD, DDRC_OP_WR: begin
				// column issue is not held back for rcd; a closed bank or al above 4 is refused
				bad = !open_q[bank] || add_lat > 3'(`DDRC_AL_MAX);
				ok  = !bad && ccd_done;
			end
			DDRC_OP_PREA:  ok = rfc_done;
			DDRC_OP_REF:   ok = rfc_done && open_q == '0;
			// update waits until termination is already off
			DDRC_OP_EMRS1: ok = rfc_done && !odt;
			DDRC_OP_SRE:   begin
				bad = need_ref_q || open_q != '0;
				ok  = !bad && rfc_done && !odt;
			end
			DDRC_OP_SRX:   ok = 1'b0;
			default:       bad = 1'b1;
		endcase
	end

	assign req_ready = (st_q == ST_RUN && (ok || bad)) ||
		(st_q == ST_SELF && req.op == DDRC_OP_SRX && stab_q[1]);
	assign issue = req_valid && req_ready && st_q == ST_RUN && ok;

	// state sequence for termination update and self refresh
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= ST_RUN;
			wait_load <= 1'b0;
			wait_val  <= '0;
		end else begin
			wait_load <= 1'b0;
			unique case (st_q)
				ST_RUN: begin
					if (req_valid && req.op == DDRC_OP_EMRS1 && rfc_done && odt) begin
						st_q      <= ST_ODT_OFF;
						wait_load <= 1'b1;
						wait_val  <= `DDRC_CNT_W'(T_AOFD);
					end else if (issue && req.op == DDRC_OP_EMRS1) begin
						st_q      <= ST_MOD_WAIT;
						wait_load <= 1'b1;
						wait_val  <= `DDRC_CNT_W'(T_MODX);
					end else if (issue && req.op == DDRC_OP_SRE) begin
						st_q <= ST_SELF;
					end
				end
				ST_ODT_OFF: if (wait_done && !wait_load) begin
					st_q <= ST_RUN;
				end
				ST_MOD_WAIT: if (wait_done && !wait_load) begin
					st_q <= ST_RUN;
				end
				ST_SELF: if (req_valid && req_ready) begin
					st_q      <= ST_EXIT;
					wait_load <= 1'b1;
					wait_val  <= `DDRC_CNT_W'(T_XSNR);
				end
				ST_EXIT: if (wait_done && !wait_load) begin
					st_q <= ST_RUN;
				end
			endcase
		end
	end

	// bank bookkeeping; auto precharge closes the row after its timer
	logic [`DDRC_BANKS-1:0] ap_load;
	logic [`DDRC_BANKS-1:0] ap_done;
	logic [`DDRC_BANKS-1:0] ap_pend_q;
	generate
		for (gi = 0; gi < `DDRC_BANKS; gi++) begin : g_ap
			ddrc_timer #(.W(`DDRC_CNT_W)) u_ap (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.load     (ap_load[gi]),
				.value    (`DDRC_CNT_W'(T_RPAP) + `DDRC_CNT_W'(add_lat)),
				.done     (ap_done[gi])
			);
			assign ap_load[gi] = issue && (req.op == DDRC_OP_RD || req.op == DDRC_OP_WR) &&
				req.auto_precharge_flag && bank == 2'(gi);
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			open_q    <= '0;
			ap_pend_q <= '0;
		end else if (issue && (req.op == DDRC_OP_PREA || req.op == DDRC_OP_REF)) begin
			open_q    <= '0;
			ap_pend_q <= '0;
		end else begin
			for (int i = 0; i < `DDRC_BANKS; i++) begin
				if (ap_load[i]) begin
					ap_pend_q[i] <= 1'b1;
				end else if (ap_pend_q[i] && ap_done[i]) begin
					ap_pend_q[i] <= 1'b0;
					open_q[i]    <= 1'b0;
				end
				if (rc_load[i]) begin
					open_q[i] <= 1'b1;
				end
			end
		end
	end

	// refresh interval and postponed count
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			refi_q     <= '0;
			posted_q   <= 4'h0;
			need_ref_q <= 1'b0;
		end else begin
			if (refi_q == `DDRC_CNT_W'(REFI_CYC - 1)) begin
				refi_q <= '0;
			end else begin
				refi_q <= refi_q + 1'b1;
			end
			if (issue && req.op == DDRC_OP_REF) begin
				need_ref_q <= 1'b0;
				if (posted_q != 4'h0 && refi_q != `DDRC_CNT_W'(REFI_CYC - 1)) begin
					posted_q <= posted_q - 1'b1;
				end
			end else if (refi_q == `DDRC_CNT_W'(REFI_CYC - 1) && st_q != ST_SELF &&
				posted_q != 4'(`DDRC_POSTED_MAX + 1)) begin
				posted_q <= posted_q + 1'b1;
			end
			if (st_q == ST_EXIT) begin
				need_ref_q <= 1'b1;
			end
		end
	end
	// when eight are posted the host must refresh next
	assign refresh_due = posted_q >= 4'(`DDRC_POSTED_MAX);

	// command pins registered; idle edges carry nop
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 2'h0, addr: 13'h0000};
			cke <= 1'b0;
		end else begin
			cmd <= mk(1'b1, 1'b1, 1'b1, 2'h0, 13'h0000);
			cke <= (st_q == ST_SELF) ? (req_valid && req_ready) : 1'b1;
			if (issue) begin
				unique case (req.op)
					DDRC_OP_ACT:   cmd <= mk(1'b0, 1'b1, 1'b1, bank, {1'b0, req.row});
					DDRC_OP_RD:    cmd <= mk(1'b1, 1'b0, 1'b1, bank,
						{2'h0, req.auto_precharge_flag, 1'b0, req.col});
					DDRC_OP_WR:    cmd <= mk(1'b1, 1'b0, 1'b0, bank,
						{2'h0, req.auto_precharge_flag, 1'b0, req.col});
					DDRC_OP_PREA:  cmd <= mk(1'b0, 1'b1, 1'b0, 2'h0,
						13'(1 << `DDRC_AP_BIT));
					DDRC_OP_REF:   cmd <= mk(1'b0, 1'b0, 1'b1, 2'h0, 13'h0000);
					DDRC_OP_EMRS1: cmd <= mk(1'b0, 1'b0, 1'b0, `DDRC_EMR1_BA, req.mode_bits);
					DDRC_OP_SRE: begin
						cmd <= mk(1'b0, 1'b0, 1'b1, 2'h0, 13'h0000);
						cke <= 1'b0;
					end
					default:       cmd <= mk(1'b1, 1'b1, 1'b1, 2'h0, 13'h0000);
				endcase
			end
		end
	end

	// termination: low through update, self refresh and exit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			odt <= 1'b0;
		end else begin
			odt <= odt_want && st_q == ST_RUN && !(req_valid && req.op == DDRC_OP_EMRS1) &&
				!(req_valid && req.op == DDRC_OP_SRE);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_error <= 1'b0;
		end else begin
			req_error <= req_valid && req_ready && bad;
		end
	end

	assign open_banks_lo   = open_q[1:0];
	assign open_banks_hi   = open_q[3:2];
	assign in_self_refresh = (st_q == ST_SELF);
endmodule : ddrc_host

/* File: tb/ddrc_host_checker.sv */
// assertions on the controller pins
`timescale 1ns/1ps
module ddrc_host_checker
	import ddrc_pkg::*;
#(
	parameter int REFI_CYC = 390
) (
	input wire logic	core_clk,
	input wire logic	nrst,
	input wire ddrc_req_s	req,
	input wire logic	req_valid,
	input wire logic	req_ready,
	input wire ddrc_cmd_s	cmd,
	input wire logic	cke,
	input wire logic	odt,
	input wire logic	in_self_refresh,
	input wire logic	req_error
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire tk = req_valid && req_ready;
	wire sel = !cmd.cs_n;
	wire col = sel && cmd.ras_n && !cmd.cas_n;
	wire act = sel && !cmd.ras_n && cmd.cas_n && cmd.we_n;
	wire rf = sel && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
	a_act_fields: assert property (tk && req.op == DDRC_OP_ACT |=> req_error || act
		&& cmd.ba == $past(req.bank) && cmd.addr[11:0] == $past(req.row)) else $error("bad activate");
	a_col_fields: assert property (tk && req.op inside {DDRC_OP_RD, DDRC_OP_WR} |=> req_error || col
		&& cmd.we_n == ($past(req.op) == DDRC_OP_RD) && cmd.ba == $past(req.bank)
		&& cmd.addr[8:0] == $past(req.col) && cmd.addr[10] == $past(req.auto_precharge_flag)) else $error("bad column");
	a_col_spacing: assert property (col |=> !col) else $error("column too close");
	a_sre_odt_off: assert property ($fell(cke) |-> rf && !odt) else $error("bad entry");
	a_sr_hold: assert property (in_self_refresh && !cke && !req_valid |=> !cke) else $error("cke rose");
	a_exit_nops: assert property ($rose(cke) && $past(in_self_refresh) |-> (!sel || cmd.ras_n && cmd.cas_n
		&& cmd.we_n) [*8]) else $error("command in exit");
	a_mode_odt_low: assert property (sel && !cmd.ras_n && !cmd.cas_n && !cmd.we_n |->
		(!odt && !$past(odt)) ##1 !odt) else $error("odt high at update");
	a_ref_spacing: assert property (rf && cke |=> !(act || rf) [*3]) else $error("refresh too close");
endmodule : ddrc_host_checker

/* File: tb/ddrc_dev_model.sv */
// behavioural ddr2 device behind the command pins
`timescale 1ns/1ps
module ddrc_dev_model
	import ddrc_pkg::*;
#(
	parameter int BL = 4,
	parameter int CL = 3,
	parameter int WR = 2,
	parameter int XSNR = 9
) (
	input wire logic	core_clk,
	input wire ddrc_cmd_s	cmd,
	input wire logic	cke,
	input wire logic	odt,
	input wire logic [2:0]	add_lat,
	output logic [3:0]	bank_open,
	output logic [7:0]	viol
);
	int ap[4] = '{default: 0};
	int xs = 0;
	int gap = 9;
	logic sr = 0;
	logic need = 0;
	wire sel = !cmd.cs_n;
	wire [2:0] rcw = {cmd.ras_n, cmd.cas_n, cmd.we_n};
	initial begin
		bank_open = '0;
		viol = '0;
	end
	// one decode per rising edge; bl is only 4 or 8
	always @(posedge core_clk) begin
		gap++;
		for (int i = 0; i < 4; i++) begin
			if (ap[i] == 1) bank_open[i] = 0;
			if (ap[i] > 0) ap[i]--;
		end
		if (sr) begin
			// every pin but cke is ignored here
			if (cke) begin
				sr = 0;
				xs = XSNR;
				need = 1;
			end
		end else if (!cke) begin
			if (sel && rcw == 3'h1) begin
				if (odt || need || bank_open != 0) viol++;
				sr = 1;
			end
		end else if (xs > 0) begin
			xs--;
			if (sel && rcw != 3'h7) viol++;
		end else if (sel) begin
			case (rcw)
			3'h3: begin
				if (bank_open[cmd.ba]) viol++;
				bank_open[cmd.ba] = 1;
			end
			3'h4, 3'h5: begin
				// burst wraps inside its segment, so column is taken as is
				if (!bank_open[cmd.ba] || gap < 2) viol++;
				gap = 0;
				if (cmd.addr[10]) ap[cmd.ba] = add_lat + BL / 2 + (rcw[0] ? 0 : CL - 1 + WR);
			end
			3'h2: if (cmd.addr[10]) bank_open = '0;
			3'h1: need = 0;
			3'h0: if (odt) viol++;
			default: ;
			endcase
		end
	end
endmodule : ddrc_dev_model

/* File: tb/tb.sv */
// random self-checking bench for the ddr2 controller
`timescale 1ns/1ps
module tb
	import ddrc_pkg::*;
;
	localparam int REFI = 20;
	logic		core_clk = 0, nrst = 0, req_valid = 0, clk_stable = 0, odt_want = 0;
	logic [2:0]	add_lat = '0;
	ddrc_req_s	req = '0;
	ddrc_cmd_s	cmd;
	logic		cke, odt, req_ready, in_sr, due, req_error;
	logic [1:0]	ob_lo, ob_hi, b;
	logic [3:0]	bo_m;
	logic [7:0]	viol;
	logic [31:0]	seed = 32'h000134EA;
	int		n_errors = 0, checks = 0;
	ddrc_host #(.REFI_CYC(REFI)) i_ddrc_host (.core_clk, .nrst, .req, .req_valid, .req_ready, .add_lat, .clk_stable,
		.odt_want, .cmd, .cke, .odt, .open_banks_lo(ob_lo), .open_banks_hi(ob_hi), .in_self_refresh(in_sr),
		.refresh_due(due), .req_error);
	ddrc_dev_model i_ddrc_dev_model (.core_clk, .cmd, .cke, .odt, .add_lat, .bank_open(bo_m), .viol);
	initial forever #10 core_clk = ~core_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [2:0] pins(ddrc_op_e op);
		case (op)
		DDRC_OP_ACT: return 3'h3;
		DDRC_OP_RD: return 3'h5;
		DDRC_OP_WR: return 3'h4;
		DDRC_OP_PREA: return 3'h2;
		DDRC_OP_EMRS1: return 3'h0;
		default: return 3'h1;
		endcase
	endfunction : pins
	task automatic summarize();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %0h want %0h", $time, got, exp);
		end
	endtask : chk
	// request held from a falling edge until taken; legal but early ones stall
	task automatic go(ddrc_op_e op, logic [1:0] bk, logic [8:0] c, logic ap, logic ee);
		int n;
		@(negedge core_clk);
		req = '{op, bk, 12'(rnd()), c, ap, 13'h0044};
		req_valid = 1;
		#1;
		for (n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge core_clk) #1;
		if (n == 400) begin
			n_errors++;
			summarize();
		end
		@(negedge core_clk);
		req_valid = 0;
		// cmd and error pulse stand for one cycle only
		chk(req_error, ee);
		if (!ee && op != DDRC_OP_SRX) chk({cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n}, {1'b0, pins(op)});
		if (!ee && op == DDRC_OP_ACT) chk({cmd.ba, cmd.addr[11:0]}, {bk, req.row});
		if (!ee && op inside {DDRC_OP_RD, DDRC_OP_WR}) chk(cmd[14:0] & 15'h65FF, {bk, 2'h0, ap, 1'b0, c});
		if (!ee && op == DDRC_OP_PREA) chk(cmd.addr[10], 1'b1);
		if (!ee && op == DDRC_OP_EMRS1) chk({cmd.ba, cmd.addr, odt}, {2'h1, 13'h0044, 1'b0});
	endtask : go
	initial begin
		repeat (8) @(negedge core_clk);
		nrst = 1;
		// internal reset copy needs two edges to release
		repeat (2) @(negedge core_clk);
		go(DDRC_OP_REF, '0, '0, '0, '0);
		repeat (6 * REFI) @(negedge core_clk);
		chk(due, 0);
		repeat (2 * REFI) @(negedge core_clk);
		chk(due, 1);
		go(DDRC_OP_REF, '0, '0, '0, '0);
		chk(due, 0);
		for (int i = 0; i < 8; i++) begin
			b = 2'(rnd());
			add_lat = 3'(rnd() % 5);
			go(DDRC_OP_ACT, b, '0, '0, '0);
			go(DDRC_OP_ACT, b, '0, '0, 1'b1);
			go(DDRC_OP_RD, b, 9'(rnd()), '0, '0);
			go(DDRC_OP_WR, b + 2'h1, '0, '0, 1'b1);
			add_lat = 3'h5;
			go(DDRC_OP_RD, b, '0, '0, 1'b1);
			add_lat = 3'(i % 5);
			go(i[0] ? DDRC_OP_RD : DDRC_OP_WR, b, 9'(rnd()), i[1], '0);
			repeat (40) @(negedge core_clk);
			chk({ob_hi, ob_lo}, bo_m);
			go(DDRC_OP_PREA, b, '0, '0, '0);
			// model decodes the precharge one edge later
			@(negedge core_clk);
			chk({ob_hi, ob_lo, bo_m}, 8'h00);
		end
		odt_want = 1;
		go(DDRC_OP_EMRS1, '0, '0, '0, '0);
		go(DDRC_OP_ACT, 2'h2, '0, '0, '0);
		go(DDRC_OP_SRE, '0, '0, '0, 1'b1);
		go(DDRC_OP_PREA, '0, '0, '0, '0);
		go(DDRC_OP_SRE, '0, '0, '0, '0);
		repeat (30) @(negedge core_clk);
		chk({cke, odt, in_sr}, 3'h1);
		clk_stable = 1;
		go(DDRC_OP_SRX, '0, '0, '0, '0);
		chk(cke, 1);
		go(DDRC_OP_SRE, '0, '0, '0, 1'b1);
		go(DDRC_OP_REF, '0, '0, '0, '0);
		go(DDRC_OP_SRE, '0, '0, '0, '0);
		chk(viol, 0);
		summarize();
	end
endmodule : tb
bind ddrc_host ddrc_host_checker #(.REFI_CYC(REFI_CYC)) i_ddrc_host_checker (.core_clk, .nrst, .req, .req_valid,
	.req_ready, .cmd, .cke, .odt, .in_self_refresh, .req_error);
